// File: common/psf_pkg.sv
// package of constants, types and carriers for the processor flags word block
package psf_pkg;

    // ==================================================================
    // register map (byte addresses on the apb bus)
    // ==================================================================
    localparam logic [7:0] PSF_FLAGS_OFFSET = 8'hD0; // processor_flags_word
    localparam logic [7:0] PSF_BITACC_OFFSET = 8'hD4; // single bit write port
    localparam logic [7:0] PSF_FLAGS_RESET = 8'h00; // every bit clear
    localparam logic [31:0] PSF_READ_ZERO = 32'h0000_0000; // unmapped read data

    // ==================================================================
    // field positions inside processor_flags_word
    // ==================================================================
    localparam int PSF_CARRY_POS = 7; // carry_out_flag
    localparam int PSF_HALF_POS = 6; // half_carry_flag
    localparam int PSF_USER0_POS = 5; // user_flag_zero
    localparam int PSF_BANK_HI_POS = 4; // bank_select_field msb
    localparam int PSF_BANK_LO_POS = 3; // bank_select_field lsb
    localparam int PSF_RANGE_POS = 2; // signed_range_flag
    localparam int PSF_USER1_POS = 1; // user_flag_one
    localparam int PSF_PARITY_POS = 0; // parity, read only

    // ==================================================================
    // bit access register layout
    // ==================================================================
    localparam int PSF_BITSEL_LSB = 0; // bits 2:0 pick the flag bit
    localparam int PSF_BITSEL_MSB = 2;
    localparam int PSF_BITVAL_POS = 3; // value written into that bit

    // ==================================================================
    // arithmetic operations reported by the core, one-hot codes
    // ==================================================================
    typedef enum logic [4:0] {
        PSF_OP_ADD = 5'h01, // add
        PSF_OP_ADD_WITH_CARRY_OP = 5'h02, // add_with_carry_op
        PSF_OP_SUBTRACT_WITH_BORROW_OP = 5'h04, // subtract_with_borrow_op
        PSF_OP_MUL = 5'h08, // multiply
        PSF_OP_DIV = 5'h10 // divide
    } psf_op_t;

    // one operation result request from the core datapath
    typedef struct packed {
        logic valid; // one-cycle strobe
        psf_op_t op; // which operation
        logic [7:0] lhs; // accumulator operand
        logic [7:0] rhs; // second operand or divisor
    } psf_alu_req_t;

    // apb request signals driven by the bus master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } psf_apb_req_t;

endpackage : psf_pkg

// File: hw/psf_flags.sv
// processor flags word: arithmetic flags, user flags, bank select and apb access
//
// What this block does
// - two user flags change only by software
// - bank code picks 8-byte register window
// - add, add_with_carry_op, subtract_with_borrow_op set overflow on sign change
// - multiply product above 255 sets overflow
// - divide by zero sets overflow
// - otherwise those operations clear overflow
// - r0-r7 resolve into the selected bank
//
// The APB slave port was chosen for this implementation.
module psf_flags (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire psf_pkg::psf_apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire psf_pkg::psf_alu_req_t alu_i,
    input wire logic [7:0] acc_i,
    input wire logic [2:0] reg_idx_i,
    output logic [7:0] flags_o,
    output logic [4:0] reg_addr_o
);

    // ==================================================================
    // state
    // ==================================================================
    logic cy_q; // carry out of bit 7 or borrow into it
    logic ac_q; // nibble carry or borrow
    logic ov_q; // signed range overflow
    logic f0_q; // software flag zero
    logic f1_q; // software flag one
    logic [1:0] bank_q; // working register bank
    logic par_q; // accumulator parity
    logic pready_q; // apb answer strobe
    logic pslverr_q; // apb error for unmapped address
    logic [31:0] prdata_q; // apb read data
    logic [4:0] reg_addr_q; // resolved register data address

    // ==================================================================
    // address decode
    // ==================================================================
    // returns {bit access hit, flags word hit}; used for read and write
    function automatic logic [1:0] psf_decode(input logic [7:0] addr);
        logic [1:0] hit;
        hit = 2'b00;
        if (addr == psf_pkg::PSF_FLAGS_OFFSET) begin
            hit = 2'b01;
        end else if (addr == psf_pkg::PSF_BITACC_OFFSET) begin
            hit = 2'b10;
        end
        return hit;
    endfunction : psf_decode

    logic [1:0] hit; // decode of the present address
    logic setup_ph; // apb setup cycle
    logic access_done; // access cycle completing now
    logic wr_flags; // whole word write this edge
    logic wr_bit; // single bit write this edge
    logic [2:0] bit_sel; // bit picked by a bit write
    logic bit_val; // value for that bit

    assign hit = psf_decode(apb_i.paddr);
    assign setup_ph = apb_i.psel && !apb_i.penable;
    assign access_done = apb_i.psel && apb_i.penable && pready_q;
    assign wr_flags = access_done && apb_i.pwrite && hit[0];
    assign wr_bit = access_done && apb_i.pwrite && hit[1];
    assign bit_sel = apb_i.pwdata[psf_pkg::PSF_BITSEL_MSB:psf_pkg::PSF_BITSEL_LSB];
    assign bit_val = apb_i.pwdata[psf_pkg::PSF_BITVAL_POS];

    // ==================================================================
    // arithmetic flag evaluation
    // ==================================================================
    logic [8:0] sum9; // add result with carry out
    logic [4:0] sum_nib; // low nibble add with carry out
    logic [8:0] dif9; // subtract result with borrow in msb
    logic [4:0] dif_nib; // low nibble subtract with borrow
    logic [15:0] prod; // full multiply product
    logic cin; // carry in, only for add_with_carry_op and subtract_with_borrow_op
    logic add_ovf; // sign change on addition
    logic sub_ovf; // sign change on subtraction

    // carry in comes from the stored flag; plain add ignores it
    assign cin = (alu_i.op == psf_pkg::PSF_OP_ADD) ? 1'b0 : cy_q;
    assign sum9 = {1'b0, alu_i.lhs} + {1'b0, alu_i.rhs} + {8'h00, cin};
    assign sum_nib = {1'b0, alu_i.lhs[3:0]} + {1'b0, alu_i.rhs[3:0]} + {4'h0, cin};
    assign dif9 = {1'b0, alu_i.lhs} - {1'b0, alu_i.rhs} - {8'h00, cin};
    assign dif_nib = {1'b0, alu_i.lhs[3:0]} - {1'b0, alu_i.rhs[3:0]} - {4'h0, cin};
    assign prod = 16'(alu_i.lhs) * 16'(alu_i.rhs);
    // same-sign operands giving a different-sign result
    assign add_ovf = (alu_i.lhs[7] == alu_i.rhs[7]) && (sum9[7] != alu_i.lhs[7]);
    // opposite-sign operands where the result leaves the minuend sign
    assign sub_ovf = (alu_i.lhs[7] != alu_i.rhs[7]) && (dif9[7] != alu_i.lhs[7]);

    // ==================================================================
    // arithmetic flags: software writes, then arithmetic wins
    // ==================================================================
    // arithmetic is applied last so a result landing with a write is not lost
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cy_q <= 1'b0;
            ac_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            if (wr_flags) begin
                cy_q <= apb_i.pwdata[psf_pkg::PSF_CARRY_POS];
                ac_q <= apb_i.pwdata[psf_pkg::PSF_HALF_POS];
                ov_q <= apb_i.pwdata[psf_pkg::PSF_RANGE_POS];
            end else if (wr_bit) begin
                // only the arithmetic bits are handled here
                if (bit_sel == 3'(psf_pkg::PSF_CARRY_POS)) begin
                    cy_q <= bit_val;
                end
                if (bit_sel == 3'(psf_pkg::PSF_HALF_POS)) begin
                    ac_q <= bit_val;
                end
                if (bit_sel == 3'(psf_pkg::PSF_RANGE_POS)) begin
                    ov_q <= bit_val;
                end
            end
            if (alu_i.valid) begin
                unique case (alu_i.op)
                    psf_pkg::PSF_OP_ADD,
                    psf_pkg::PSF_OP_ADD_WITH_CARRY_OP: begin
                        cy_q <= sum9[8];
                        ac_q <= sum_nib[4];
                        ov_q <= add_ovf;
                    end
                    psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW_OP: begin
                        cy_q <= dif9[8];
                        ac_q <= dif_nib[4];
                        ov_q <= sub_ovf;
                    end
                    psf_pkg::PSF_OP_MUL: begin
                        // carry always clears; half carry is left alone
                        cy_q <= 1'b0;
                        ov_q <= |prod[15:8];
                    end
                    psf_pkg::PSF_OP_DIV: begin
                        cy_q <= 1'b0;
                        ov_q <= (alu_i.rhs == 8'h00);
                    end
                    default: begin
                        // non one-hot code: flags hold
                    end
                endcase
            end
        end
    end

    // ==================================================================
    // software-owned bits: user flags and bank select
    // ==================================================================
    // arithmetic never reaches these bits
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            f0_q <= 1'b0;
            f1_q <= 1'b0;
            bank_q <= 2'b00;
        end else if (wr_flags) begin
            f0_q <= apb_i.pwdata[psf_pkg::PSF_USER0_POS];
            f1_q <= apb_i.pwdata[psf_pkg::PSF_USER1_POS];
            bank_q <= apb_i.pwdata[psf_pkg::PSF_BANK_HI_POS:psf_pkg::PSF_BANK_LO_POS];
        end else if (wr_bit) begin
            // single bit access, the bit-addressable path
            if (bit_sel == 3'(psf_pkg::PSF_USER0_POS)) begin
                f0_q <= bit_val;
            end
            if (bit_sel == 3'(psf_pkg::PSF_USER1_POS)) begin
                f1_q <= bit_val;
            end
            if (bit_sel == 3'(psf_pkg::PSF_BANK_HI_POS)) begin
                bank_q[1] <= bit_val;
            end
            if (bit_sel == 3'(psf_pkg::PSF_BANK_LO_POS)) begin
                bank_q[0] <= bit_val;
            end
        end
    end

    // ==================================================================
    // parity of the accumulator
    // ==================================================================
    // one cycle behind the accumulator so the output comes from a flop;
    // writes cannot touch it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            par_q <= 1'b0;
        end else begin
            par_q <= ^acc_i;
        end
    end

    // ==================================================================
    // register operand resolution
    // ==================================================================
    // bank code forms the two high address bits over the operand index
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_addr_q <= 5'h00;
        end else begin
            reg_addr_q <= {bank_q, reg_idx_i};
        end
    end

    // ==================================================================
    // apb slave: answer in the first access cycle
    // ==================================================================
    // read data is captured in setup; a flag changing in that one cycle
    // shows up on the next read, which is the trade for a flop output
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= psf_pkg::PSF_READ_ZERO;
        end else begin
            pready_q <= setup_ph;
            if (setup_ph) begin
                pslverr_q <= (hit == 2'b00);
                if (!apb_i.pwrite && hit[0]) begin
                    prdata_q <= {24'h00_0000, flags_o};
                end else begin
                    // bit access register and unmapped space read zero
                    prdata_q <= psf_pkg::PSF_READ_ZERO;
                end
            end else if (access_done) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // outputs
    // ==================================================================
    assign flags_o = {cy_q, ac_q, f0_q, bank_q, ov_q, f1_q, par_q};
    assign reg_addr_o = reg_addr_q;
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

    // ==================================================================
    // assertions
    // ==================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic sw_wr; // any software write this edge
    assign sw_wr = wr_flags || wr_bit;

    a_user_flags_hold: assert property (alu_i.valid && !sw_wr |=> $stable(f0_q) && $stable(f1_q))
        else $error("user flag changed without a software write");

    // sign-extended subtract with borrow; the top three bits disagree only
    // when the true result leaves the signed byte range
    logic [9:0] sdiff; // wide signed difference for the checker
    assign sdiff = {{2{alu_i.lhs[7]}}, alu_i.lhs} - {{2{alu_i.rhs[7]}}, alu_i.rhs} - {9'h000, cy_q};

    a_bank_addr_range: assert property (1'b1 |=> (reg_addr_o >= {$past(bank_q), 3'h0})
        && (reg_addr_o <= {$past(bank_q), 3'h7}))
        else $error("register address outside selected bank window");

    a_reg_operand_map: assert property (1'b1 |=> reg_addr_o[2:0] == $past(reg_idx_i))
        else $error("register operand index not preserved");

    a_ov_add_sign: assert property (alu_i.valid && alu_i.op == psf_pkg::PSF_OP_ADD
        && alu_i.lhs[7] == alu_i.rhs[7] && 8'(alu_i.lhs + alu_i.rhs) >> 7 != 8'(alu_i.lhs[7])
        |=> ov_q)
        else $error("add sign overflow did not set overflow");

    a_ov_sub_sign: assert property (alu_i.valid && alu_i.op == psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW_OP
        |=> ov_q == ($past(sdiff[9:7]) != 3'b000 && $past(sdiff[9:7]) != 3'b111))
        else $error("subtract overflow flag wrong");

    a_ov_mul_big: assert property (alu_i.valid && alu_i.op == psf_pkg::PSF_OP_MUL
        && (16'(alu_i.lhs) * 16'(alu_i.rhs)) > 16'h00FF |=> ov_q && !cy_q)
        else $error("large product did not set overflow");

    a_ov_div_zero: assert property (alu_i.valid && alu_i.op == psf_pkg::PSF_OP_DIV
        && alu_i.rhs == 8'h00 |=> ov_q)
        else $error("divide by zero did not set overflow");

    a_ov_div_clear: assert property (alu_i.valid && alu_i.op == psf_pkg::PSF_OP_DIV
        && alu_i.rhs != 8'h00 |=> !ov_q)
        else $error("valid divide did not clear overflow");

    // carry out of an add happens exactly when lhs exceeds the room left above rhs
    a_carry_add_out: assert property (alu_i.valid && alu_i.op == psf_pkg::PSF_OP_ADD
        |=> cy_q == ($past(alu_i.lhs) > (8'hFF - $past(alu_i.rhs))))
        else $error("carry flag does not match add carry out");

    a_half_add_nib: assert property (alu_i.valid && alu_i.op == psf_pkg::PSF_OP_ADD
        |=> ac_q == ($past(alu_i.lhs[3:0]) > (4'hF - $past(alu_i.rhs[3:0]))))
        else $error("half carry flag does not match nibble carry");

    a_parity_follow: assert property (1'b1 |-> ##1 par_q == ^$past(acc_i))
        else $error("parity does not follow accumulator");

    a_apb_ready_once: assert property (setup_ph |=> pready_o ##1 !pready_o)
        else $error("apb answer not a single cycle after setup");

    c_mul_overflow: cover property (alu_i.valid && alu_i.op == psf_pkg::PSF_OP_MUL ##1 ov_q);
    c_bank_three: cover property (wr_flags ##1 bank_q == 2'b11);
    c_unmapped_err: cover property (access_done && pslverr_o);
    c_div_zero: cover property (alu_i.valid && alu_i.op == psf_pkg::PSF_OP_DIV && alu_i.rhs == 8'h00);
    c_bit_write: cover property (wr_bit && bit_sel == 3'(psf_pkg::PSF_USER1_POS));

endmodule : psf_flags

// File: testbench/psf_flags_test.sv
// self-checking testbench for the processor flags word block
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module psf_flags_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // signals and model state
    // ==================================================================
    logic clk_i = 1'b0; // core clock
    logic rst_i = 1'b1; // async reset, high
    psf_pkg::psf_apb_req_t apb_i; // bus request
    psf_pkg::psf_alu_req_t alu_i; // arithmetic result strobe
    logic [7:0] acc_i; // accumulator
    logic [2:0] reg_idx_i; // register operand index
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [7:0] flags_o;
    logic [4:0] reg_addr_o;
    int failures = 0;
    int comparisons = 0;
    integer seed = 32'h52AD; // fixed seed, repeatable runs
    logic [7:0] m_word; // model word, bit 0 unused
    logic [7:0] acc_prev; // parity lags the accumulator
    logic [7:0] acc_new, lhs, rhs;
    logic [4:0] ops [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03}; // last is not one-hot
    logic [31:0] rd; // read data taken at pready
    logic err; // error taken at pready

    always #5 clk_i = ~clk_i; // 100 mhz

    psf_flags u_dut (.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .alu_i(alu_i), .acc_i(acc_i), .reg_idx_i(reg_idx_i), .flags_o(flags_o),
        .reg_addr_o(reg_addr_o));

    // ==================================================================
    // helpers
    // ==================================================================
    // expected word: model bits plus parity of the held accumulator
    function automatic logic [7:0] exp_word();
        return {m_word[7:1], ^acc_prev};
    endfunction : exp_word

    // one apb transfer; holds the request until pready is sampled
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        // slave never answered: counted, and the run ends in a fail
        if (n >= 20) begin
            failures++;
            $display("Error at %0t: no answer, got %0h expected %0h", $time, pready_o, 1'b1);
        end
        rd = prdata_o;
        err = pslverr_o;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask : apb

    // reference arithmetic flags, carry-in is the stored carry only for add with carry and subtract with borrow
    task automatic model_alu(input logic [4:0] op, input logic [7:0] a, input logic [7:0] b);
        int s, h, c;
        logic [7:0] r;
        c = (op == 5'h02 || op == 5'h04) ? int'(m_word[7]) : 0;
        case (op)
            5'h01, 5'h02: begin // add, add with carry
                s = a + b + c;
                h = (a & 15) + (b & 15) + c;
                r = s[7:0];
                m_word[7] = s > 255;
                m_word[6] = h > 15;
                m_word[2] = (a[7] == b[7]) && (r[7] != a[7]);
            end
            5'h04: begin // subtract with borrow
                s = a - b - c;
                h = (a & 15) - (b & 15) - c;
                r = s[7:0];
                m_word[7] = s < 0;
                m_word[6] = h < 0;
                m_word[2] = (a[7] != b[7]) && (r[7] != a[7]);
            end
            5'h08: begin // multiply
                m_word[7] = 1'b0;
                m_word[2] = (a * b) > 255;
            end
            5'h10: begin // divide
                m_word[7] = 1'b0;
                m_word[2] = (b == 0);
            end
            default: ; // refused code leaves flags alone
        endcase
    endtask : model_alu

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // ==================================================================
    // watchdog, far beyond the expected run
    // ==================================================================
    initial begin
        #50000;
        failures++;
        $display("Error at %0t: watchdog expired, got %0h expected %0h", $time, comparisons, 0);
        print_verdict();
    end

    // ==================================================================
    // main sequence
    // ==================================================================
    initial begin
        apb_i = '0;
        alu_i = '0;
        acc_i = 8'h00;
        reg_idx_i = 3'h0;
        m_word = 8'h00;
        acc_prev = 8'h00;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset value and full write, parity bit cannot be written
        apb(1'b0, psf_pkg::PSF_FLAGS_OFFSET, 32'h0);
        `CHK(rd, {24'h0, psf_pkg::PSF_FLAGS_RESET})
        `CHK(err, 1'b0)
        apb(1'b1, psf_pkg::PSF_FLAGS_OFFSET, 32'hFF);
        m_word = 8'hFE;
        apb(1'b0, psf_pkg::PSF_FLAGS_OFFSET, 32'h0);
        `CHK(rd, {24'h0, exp_word()})
        `CHK(flags_o, exp_word())
        // unmapped place: error, write dropped, read zero
        apb(1'b1, 8'hC0, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b0, 8'hC0, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b0, psf_pkg::PSF_FLAGS_OFFSET, 32'h0);
        `CHK(rd[7:0], exp_word())
        $display("test register access done");
        // single bit port flips each bit; parity must stay put
        for (int b = 0; b < 8; b++) begin
            apb(1'b1, psf_pkg::PSF_BITACC_OFFSET, {28'h0, ~m_word[b], b[2:0]});
            if (b != 0) m_word[b] = ~m_word[b];
            apb(1'b0, psf_pkg::PSF_FLAGS_OFFSET, 32'h0);
            `CHK(rd[7:0], exp_word())
        end
        apb(1'b0, psf_pkg::PSF_BITACC_OFFSET, 32'h0);
        `CHK(rd, 32'h0)
        $display("test bit access done");
        // every bank code and every register index
        for (int bk = 0; bk < 4; bk++) begin
            m_word[4:3] = bk[1:0];
            apb(1'b1, psf_pkg::PSF_FLAGS_OFFSET, {24'h0, m_word});
            for (int ix = 0; ix < 8; ix++) begin
                @(posedge clk_i);
                reg_idx_i <= ix[2:0];
                @(posedge clk_i);
                #1;
                `CHK(reg_addr_o, {bk[1:0], ix[2:0]})
            end
        end
        $display("test bank select done");
        // back-to-back arithmetic results with a moving accumulator
        for (int i = 0; i <= 72; i++) begin
            lhs = $random(seed);
            rhs = $random(seed);
            acc_new = $random(seed);
            if (i % 12 == 3) begin
                lhs = lhs & 8'h0F; // small product, no overflow
                rhs = rhs & 8'h0F;
            end
            if (i % 6 == 4 && ($random(seed) & 1) == 0) rhs = 8'h00; // zero divisor
            @(posedge clk_i);
            alu_i <= '{valid: (i < 72), op: psf_pkg::psf_op_t'(ops[i % 6]), lhs: lhs, rhs: rhs};
            acc_i <= acc_new;
            #1;
            if (i > 0) `CHK(flags_o, exp_word())
            if (i < 72) model_alu(ops[i % 6], lhs, rhs);
            acc_prev = acc_new;
        end
        $display("test arithmetic flags done");
        // reset in mid-run clears the word
        @(posedge clk_i);
        rst_i <= 1'b1;
        #1;
        `CHK(flags_o, psf_pkg::PSF_FLAGS_RESET)
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        m_word = 8'h00;
        apb(1'b0, psf_pkg::PSF_FLAGS_OFFSET, 32'h0);
        `CHK(rd, {24'h0, exp_word()})
        $display("test second reset done");
        print_verdict();
    end

endmodule : psf_flags_test
